// ---- doalu_cfg.svh ----
`ifndef DOALU_CFG_SVH
`define DOALU_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define DOALU_OFF_INSTR   5'h00
`define DOALU_OFF_SRC     5'h04
`define DOALU_OFF_DST     5'h08
`define DOALU_OFF_CTRL    5'h0C
`define DOALU_OFF_RESULT  5'h10
`define DOALU_OFF_STATUS  5'h14

// Control register fields.
`define DOALU_CTRL_GO     0
`define DOALU_CTRL_TREG   1

// Status register fields.
`define DOALU_ST_C        0
`define DOALU_ST_V        1
`define DOALU_ST_Z        2
`define DOALU_ST_N        3
`define DOALU_ST_WB       4
`define DOALU_ST_DONE     5

// Instruction field positions.
`define DOALU_IR_BYTE     15
`define DOALU_IR_OP_HI    14
`define DOALU_IR_OP_LO    12
`define DOALU_IR_SRC_HI   11
`define DOALU_IR_SRC_LO   6

// Response codes.
`define DOALU_RESP_OKAY   2'h0
`define DOALU_RESP_SLVERR 2'h2

`endif

// ---- doalu_pkg.sv ----
package doalu_pkg;

    // Operation selected by the instruction group and byte bit.
    // Three-bit four-state base so the code can travel on a net between modules.
    typedef enum logic [2:0] {
        DOALU_NONE,
        DOALU_COPY,
        DOALU_COMPARE,
        DOALU_AND_TEST,
        DOALU_MASK_CLEAR,
        DOALU_OR_SET,
        DOALU_SUM,
        DOALU_DIFF
    } doalu_op_t;

    // Decoded instruction.
    typedef struct packed {
        logic       byte_mode;
        logic [2:0] src_mode;
        logic [2:0] src_reg;
        logic [2:0] target_mode;
        logic [2:0] target_spec;
    } doalu_dec_t;

    // Condition flags.
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } doalu_flags_t;

    // Result of one execution.
    typedef struct packed {
        logic [15:0]  value;
        logic         write_back;
        doalu_flags_t flags;
    } doalu_res_t;

endpackage

// ---- doalu_decode.sv ----
`timescale 1ns/1ps
`include "doalu_cfg.svh"

// Splits an instruction word into the operation and its operand specifiers.
module doalu_decode
    import doalu_pkg::*;
(
    input  wire logic [15:0] instr,
    output doalu_op_t        op,
    output doalu_dec_t       dec
);

    logic [2:0] grp;

    assign grp = instr[`DOALU_IR_OP_HI:`DOALU_IR_OP_LO];

    // Bit 15 is the byte select except in group 6, where it means difference.
    always_comb begin
        unique case (grp)
            3'h1:    op = DOALU_COPY;
            3'h2:    op = DOALU_COMPARE;
            3'h3:    op = DOALU_AND_TEST;
            3'h4:    op = DOALU_MASK_CLEAR;
            3'h5:    op = DOALU_OR_SET;
            3'h6:    op = instr[`DOALU_IR_BYTE] ? DOALU_DIFF : DOALU_SUM;
            default: op = DOALU_NONE;
        endcase
    end

    // The six-bit source field is a mode and a register number.
    assign dec.src_mode    = instr[`DOALU_IR_SRC_HI:9];
    assign dec.src_reg     = instr[8:`DOALU_IR_SRC_LO];
    assign dec.target_mode = instr[5:3];
    assign dec.target_spec = instr[2:0];
    assign dec.byte_mode   = instr[`DOALU_IR_BYTE] && (grp != 3'h6);

endmodule // doalu_decode

// ---- doalu_exec.sv ----
`timescale 1ns/1ps
`include "doalu_cfg.svh"

// Combinational datapath: result, write-back decision and flags.
module doalu_exec
    import doalu_pkg::*;
(
    input  wire doalu_op_t    op,
    input  wire logic         byte_mode,
    input  wire logic         to_reg,
    input  wire logic [15:0]  src,
    input  wire logic [15:0]  dst,
    input  wire doalu_flags_t old_flags,
    output doalu_res_t        res
);

    // Adds a + b + cin at word or byte width; bit 16 is the carry out of the top bit.
    function automatic logic [16:0] add_w(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin, input logic bm);
        logic [8:0] lo;
        if (bm) begin
            lo    = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
            add_w = {lo[8], 8'h00, lo[7:0]};
        end else begin
            add_w = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
        end
    endfunction

    logic [16:0] sum;
    logic [15:0] r;
    logic        sa;
    logic        sb;
    logic        sr;
    logic        zr;

    always_comb begin
        sum = 17'h00000;
        r   = 16'h0000;
        sa  = 1'b0;
        sb  = 1'b0;
        res = '0;
        res.flags = old_flags;
        unique case (op)
            DOALU_COMPARE: sum = add_w(src, ~dst, 1'b1, byte_mode);
            DOALU_SUM:     sum = add_w(src, dst, 1'b0, 1'b0);
            DOALU_DIFF:    sum = add_w(dst, ~src, 1'b1, 1'b0);
            default:       sum = 17'h00000;
        endcase
        unique case (op)
            DOALU_COPY:       r = src;
            DOALU_AND_TEST:   r = src & dst;
            DOALU_MASK_CLEAR: r = ~src & dst;
            DOALU_OR_SET:     r = src | dst;
            DOALU_NONE:       r = dst;
            default:          r = sum[15:0];
        endcase
        // Byte forms judge sign and zero on the low byte only.
        sr = byte_mode ? r[7] : r[15];
        zr = byte_mode ? (r[7:0] == 8'h00) : (r == 16'h0000);
        sa = byte_mode ? src[7] : src[15];
        sb = byte_mode ? dst[7] : dst[15];
        res.value = byte_mode ? {dst[15:8], r[7:0]} : r;
        if (op == DOALU_COPY && byte_mode && to_reg) begin
            res.value = {{8{r[7]}}, r[7:0]};
        end
        res.write_back = (op == DOALU_COPY) || (op == DOALU_MASK_CLEAR) ||
                         (op == DOALU_OR_SET) || (op == DOALU_SUM) || (op == DOALU_DIFF);
        if (op != DOALU_NONE) begin
            res.flags.n = sr;
            res.flags.z = zr;
            res.flags.v = 1'b0;
        end
        unique case (op)
            DOALU_COMPARE: begin
                res.flags.v = (sa != sb) && (sb == sr);
                res.flags.c = ~sum[16];
            end
            DOALU_SUM: begin
                res.flags.v = (sa == sb) && (sr != sa);
                res.flags.c = sum[16];
            end
            DOALU_DIFF: begin
                res.flags.v = (sa != sb) && (sa == sr);
                res.flags.c = ~sum[16];
            end
            default: res.flags.c = old_flags.c;
        endcase
    end

endmodule // doalu_exec

// ---- doalu_top.sv ----
`timescale 1ns/1ps
`include "doalu_cfg.svh"

// What this block does
// - Copy writes source to destination, source untouched.
// - Copy sets N and Z from source, clears V, keeps C.
// - Byte copy into a register sign-extends the low byte.
// - Byte forms act on low byte, flags from byte result.
// - Compare forms source plus inverted destination plus one; flags only.
// - Compare V: operands differ in sign, destination sign equals result sign.
// - Compare and difference C is the inverted carry out, a borrow.
// - AND-test forms source AND destination, flags only.
// - Mask-clear writes inverted source AND destination.
// - OR-set writes source OR destination.
// - Logic ops: N from top bit, Z on zero, V cleared, C kept.
// - Sum adds source and destination in two's complement, writes destination.
// - Sum V: same-sign operands give opposite-sign result.
// - Sum C is the carry out of the top bit.
// - Difference writes destination plus inverted source plus one.
// - Difference V: operands differ, source sign equals result sign.
// - Arithmetic ops set N on negative, Z on zero result.
// - Source field is an addressing mode plus a register number.
module doalu_top
    import doalu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and the datapath.

    logic [15:0]  instr_reg;
    logic [15:0]  src_reg;
    logic [15:0]  dst_reg;
    logic         treg_reg;
    logic [15:0]  result_reg;
    doalu_flags_t flags_reg;
    logic         wb_reg;
    logic         done_reg;
    logic         go_pulse;
    logic         treg_now;
    doalu_op_t    op;
    doalu_dec_t   dec;
    doalu_res_t   res;

    doalu_decode doalu_decode_inst (
        .instr (instr_reg),
        .op    (op),
        .dec   (dec)
    );

    doalu_exec doalu_exec_inst (
        .op        (op),
        .byte_mode (dec.byte_mode),
        .to_reg    (treg_now),
        .src       (src_reg),
        .dst       (dst_reg),
        .old_flags (flags_reg),
        .res       (res)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel. Address and data are latched independently, so
    // the master may present them in either order.

    logic [4:0]  aw_addr_reg;
    logic        aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_have_reg;
    logic        do_write;
    logic        wr_hit;

    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // Collect the address beat.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 5'h00;
            s_axi_awready <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_reg <= 1'b0;
            end
        end
    end

    // Collect the data beat.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            s_axi_wready <= !w_have_reg && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_addr_reg)
            `DOALU_OFF_INSTR, `DOALU_OFF_SRC, `DOALU_OFF_DST, `DOALU_OFF_CTRL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response; unmapped or read-only offsets answer SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DOALU_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `DOALU_RESP_OKAY : `DOALU_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Operand registers take the low two byte lanes only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_reg <= 16'h0000;
            src_reg   <= 16'h0000;
            dst_reg   <= 16'h0000;
            treg_reg  <= 1'b0;
        end else if (ce && do_write) begin
            unique case (aw_addr_reg)
                `DOALU_OFF_INSTR: begin
                    if (w_strb_reg[0]) instr_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) instr_reg[15:8] <= w_data_reg[15:8];
                end
                `DOALU_OFF_SRC: begin
                    if (w_strb_reg[0]) src_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) src_reg[15:8] <= w_data_reg[15:8];
                end
                `DOALU_OFF_DST: begin
                    if (w_strb_reg[0]) dst_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) dst_reg[15:8] <= w_data_reg[15:8];
                end
                `DOALU_OFF_CTRL: begin
                    if (w_strb_reg[0]) treg_reg <= w_data_reg[`DOALU_CTRL_TREG];
                end
                default: ;
            endcase
        end
    end

    assign go_pulse = ce && do_write && (aw_addr_reg == `DOALU_OFF_CTRL) &&
                      w_strb_reg[0] && w_data_reg[`DOALU_CTRL_GO];

    // The target flag written with GO must steer that same execution, so it is
    // taken from the write beat rather than from the register it lands in.
    assign treg_now = go_pulse ? w_data_reg[`DOALU_CTRL_TREG] : treg_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Execution: a GO write captures result and flags on the same edge that performs the write. The flags
    // persist so that operations which keep C see the previous value.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= 16'h0000;
            flags_reg  <= '0;
            wb_reg     <= 1'b0;
            done_reg   <= 1'b0;
        end else if (go_pulse) begin
            result_reg <= res.write_back ? res.value : dst_reg;
            flags_reg  <= res.flags;
            wb_reg     <= res.write_back;
            done_reg   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        unique case (s_axi_araddr)
            `DOALU_OFF_INSTR:  rd_word = {16'h0000, instr_reg};
            `DOALU_OFF_SRC:    rd_word = {16'h0000, src_reg};
            `DOALU_OFF_DST:    rd_word = {16'h0000, dst_reg};
            `DOALU_OFF_CTRL:   rd_word = {30'h00000000, treg_reg, 1'b0};
            `DOALU_OFF_RESULT: rd_word = {16'h0000, result_reg};
            `DOALU_OFF_STATUS: rd_word = {26'h0000000, done_reg, wb_reg, flags_reg.n,
                                          flags_reg.z, flags_reg.v, flags_reg.c};
            default:           rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DOALU_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? `DOALU_RESP_OKAY : `DOALU_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions on the captured result.

    sequence s_go;
        go_pulse;
    endsequence

    property p_copy_result;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_COPY && !dec.byte_mode) |=> (result_reg == $past(src_reg));
    endproperty
    a_copy_result: assert property (p_copy_result) else $error("copy result wrong");

    property p_copy_flags;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_COPY) |=> (!flags_reg.v && flags_reg.c == $past(flags_reg.c));
    endproperty
    a_copy_flags: assert property (p_copy_flags) else $error("copy flags wrong");

    property p_sext;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_COPY && dec.byte_mode && treg_now) |=> (result_reg[15:8] == {8{result_reg[7]}});
    endproperty
    a_sext: assert property (p_sext) else $error("byte copy not sign extended");

    property p_cmp_keeps;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_COMPARE) |=> (!wb_reg && result_reg == dst_reg);
    endproperty
    a_cmp_keeps: assert property (p_cmp_keeps) else $error("compare wrote destination");

    property p_cmp_word_c;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_COMPARE && !dec.byte_mode) |=> (flags_reg.c == ($past(src_reg) < $past(dst_reg)));
    endproperty
    a_cmp_word_c: assert property (p_cmp_word_c) else $error("compare borrow wrong");

    property p_sum;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_SUM) |=>
            ({flags_reg.c, result_reg} == {1'b0, $past(src_reg)} + {1'b0, $past(dst_reg)});
    endproperty
    a_sum: assert property (p_sum) else $error("sum or carry wrong");

    property p_diff;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_DIFF) |=>
            (result_reg == 16'($past(dst_reg) - $past(src_reg)) && flags_reg.c == ($past(dst_reg) < $past(src_reg)));
    endproperty
    a_diff: assert property (p_diff) else $error("difference wrong");

    property p_logic_flags;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_OR_SET || op == DOALU_MASK_CLEAR || op == DOALU_AND_TEST) |=>
            (!flags_reg.v && flags_reg.c == $past(flags_reg.c));
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");

    property p_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_go ##0 (op == DOALU_SUM || op == DOALU_DIFF) |=> (flags_reg.z == (result_reg == 16'h0000));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule // doalu_top

// ---- double_operand_alu_tb.sv ----
`timescale 1ns/1ps
`include "doalu_cfg.svh"

module double_operand_alu_tb
    import doalu_pkg::*;
;
    `define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
        $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic [4:0]   s_axi_awaddr = 5'h00;
    logic         s_axi_awvalid = 1'b0;
    logic         s_axi_awready;
    logic [31:0]  s_axi_wdata = 32'h00000000;
    logic         s_axi_wvalid = 1'b0;
    logic         s_axi_wready;
    logic [1:0]   s_axi_bresp;
    logic         s_axi_bvalid;
    logic         s_axi_bready = 1'b0;
    logic [4:0]   s_axi_araddr = 5'h00;
    logic         s_axi_arvalid = 1'b0;
    logic         s_axi_arready;
    logic [31:0]  s_axi_rdata;
    logic [1:0]   s_axi_rresp;
    logic         s_axi_rvalid;
    logic         s_axi_rready = 1'b0;
    int           miscompares = 0;
    int           n_checks = 0;
    doalu_flags_t flags_now = 4'h0;
    logic [31:0]  rd;

    // The clock enable is tied high: a frozen bus would only stall the handshakes.
    doalu_top doalu_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    // Clock at 200 MHz.
    always #2.5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Write with both beats offered together; each is dropped when it is taken.
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        // No answer time is assumed; only the watchdog ends a stuck wait.
        do begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    // Read; data and response are taken at the edge where rvalid is seen.
    task automatic axi_rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
        logic ar;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar = 1'b1;
        do begin
            @(posedge aclk);
            if (ar && s_axi_arready === 1'b1) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, s_axi_rresp)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Expected behaviour. Byte operands ride in the upper half, so carry and sign
    // come from bit 16 and bit 15 for both widths with one adder.
    function automatic doalu_res_t model(input logic [15:0] ir, s, d, input logic tr, input doalu_flags_t f);
        doalu_res_t  o;
        logic        bm;
        logic [15:0] sx;
        logic [15:0] dx;
        logic [15:0] r;
        logic [16:0] t;
        bm = ir[15] && (ir[14:12] != 3'h6);
        sx = bm ? {s[7:0], 8'h00} : s;
        dx = bm ? {d[7:0], 8'h00} : d;
        o.flags = f; o.flags.v = 1'b0; o.write_back = 1'b1; o.value = d; r = 16'h0000;
        case (ir[14:12])
            3'h1: r = sx;
            3'h2: begin
                t = {1'b0, sx} + {1'b0, ~dx} + 17'h00001; r = t[15:0]; o.write_back = 1'b0;
                o.flags.c = ~t[16]; o.flags.v = (sx[15] != dx[15]) && (dx[15] == r[15]);
            end
            3'h3: begin r = sx & dx; o.write_back = 1'b0; end
            3'h4: r = ~sx & dx;
            3'h5: r = sx | dx;
            3'h6: if (ir[15]) begin
                t = {1'b0, dx} + {1'b0, ~sx} + 17'h00001; r = t[15:0];
                o.flags.c = ~t[16]; o.flags.v = (sx[15] != dx[15]) && (sx[15] == r[15]);
            end else begin
                t = {1'b0, sx} + {1'b0, dx}; r = t[15:0];
                o.flags.c = t[16]; o.flags.v = (sx[15] == dx[15]) && (r[15] != sx[15]);
            end
            default: begin o.flags = f; o.write_back = 1'b0; return o; end
        endcase
        o.flags.n = r[15];
        o.flags.z = (r == 16'h0000);
        if (o.write_back && !bm) o.value = r;
        else if (o.write_back && ir[14:12] == 3'h1 && tr) o.value = {{8{r[15]}}, r[15:8]};
        else if (o.write_back) o.value = {d[15:8], r[15:8]};
        return o;
    endfunction

    // One instruction: load operands, fire GO, then check result, status and the source operand.
    task automatic exec(input logic [15:0] ir, s, d, input logic tr);
        doalu_res_t e;
        logic [31:0] v;
        e = model(ir, s, d, tr, flags_now);
        flags_now = e.flags;
        axi_wr(`DOALU_OFF_INSTR, {16'h0000, ir}, `DOALU_RESP_OKAY);
        axi_wr(`DOALU_OFF_SRC, {16'h0000, s}, `DOALU_RESP_OKAY);
        axi_wr(`DOALU_OFF_DST, {16'h0000, d}, `DOALU_RESP_OKAY);
        axi_wr(`DOALU_OFF_CTRL, {30'h00000000, tr, 1'b1}, `DOALU_RESP_OKAY);
        axi_rd(`DOALU_OFF_RESULT, `DOALU_RESP_OKAY, v);
        `CHK("result", {16'h0000, e.value}, v)
        axi_rd(`DOALU_OFF_STATUS, `DOALU_RESP_OKAY, v);
        `CHK("status", {26'h0000000, 1'b1, e.write_back, e.flags}, v)
        axi_rd(`DOALU_OFF_SRC, `DOALU_RESP_OKAY, v);
        `CHK("source", {16'h0000, s}, v)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog at 20000 cycles, well past the several hundred cycles the tests need.
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`DOALU_OFF_STATUS, `DOALU_RESP_OKAY, rd);
        `CHK("status after reset", 32'h00000000, rd)
        $display("test reset done");
        exec(16'h1041, 16'h8000, 16'h1234, 1'b0);
        exec(16'h1041, 16'h0000, 16'hFFFF, 1'b0);
        exec(16'h9041, 16'h0080, 16'h5555, 1'b1);
        exec(16'h9041, 16'h1280, 16'h5555, 1'b0);
        exec(16'h6041, 16'hFFFF, 16'h0001, 1'b0);
        exec(16'h1FC1, 16'h0001, 16'h0000, 1'b0);
        exec(16'h6041, 16'h7FFF, 16'h0001, 1'b0);
        exec(16'h6041, 16'h8000, 16'h8000, 1'b0);
        exec(16'h2041, 16'h0005, 16'h0005, 1'b0);
        exec(16'h2041, 16'h0001, 16'h0002, 1'b0);
        exec(16'h2041, 16'h8000, 16'h0001, 1'b0);
        exec(16'hA041, 16'h0080, 16'h0001, 1'b0);
        exec(16'h3041, 16'hF0F0, 16'h0F0F, 1'b0);
        exec(16'hB041, 16'h0080, 16'h00FF, 1'b0);
        exec(16'h4041, 16'h00FF, 16'h12FF, 1'b0);
        exec(16'hC041, 16'h00F0, 16'hAB8F, 1'b0);
        exec(16'h5041, 16'h8000, 16'h0001, 1'b0);
        exec(16'hD041, 16'h0000, 16'hAA00, 1'b0);
        exec(16'hE041, 16'h0001, 16'h0000, 1'b0);
        exec(16'hE041, 16'h0001, 16'h8000, 1'b0);
        exec(16'hE041, 16'h1234, 16'h1234, 1'b0);
        exec(16'h0041, 16'h1111, 16'h2222, 1'b0);
        exec(16'h7041, 16'h0000, 16'h0000, 1'b0);
        $display("test operations done");
        // GO reads back as zero; unmapped and read-only places are refused.
        axi_rd(`DOALU_OFF_CTRL, `DOALU_RESP_OKAY, rd);
        `CHK("ctrl go", 1'b0, rd[`DOALU_CTRL_GO])
        axi_wr(`DOALU_OFF_RESULT, 32'h0000FFFF, `DOALU_RESP_SLVERR);
        axi_wr(5'h1C, 32'h00000001, `DOALU_RESP_SLVERR);
        axi_rd(5'h18, `DOALU_RESP_SLVERR, rd);
        $display("test bus done");
        give_verdict();
    end
endmodule // double_operand_alu_tb
